// [bench/lmpf_core_monitor.sv]
// Checker for the mode and protection sequencer outputs
module lmpf_core_monitor #(
  parameter [7:0] RAMP_STEPS = 8'h40
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Watched pins
  input wire fb_above_stby_in,
  input wire supply_low_in,
  input wire pfc_gate_out,
  input wire high_gate_out,
  input wire low_gate_out,
  input wire bias_assist_en,
  input wire [7:0] ramp_level,
  input wire standby,
  input wire bootstrap_lockout,
  input wire bridge_overload,
  input wire thermal_shutdown,
  input wire cap_flip
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  gates_excl_a: assert property (!(high_gate_out && low_gate_out)) else $error("both bridge gates on");
  stby_entry_a: assert property ($rose(standby) |-> !$past(fb_above_stby_in, 40))
    else $error("standby set without long low feedback");
  stby_pfc_a: assert property (standby && $past(standby) |-> !pfc_gate_out)
    else $error("pfc gate on in standby");
  ramp_bound_a: assert property (ramp_level <= RAMP_STEPS) else $error("ramp past its top");
  ramp_step_a: assert property ($changed(ramp_level) |-> ramp_level == 8'h00 ||
    (ramp_level - $past(ramp_level)) inside {8'h01, 8'hff}) else $error("ramp jumped");
  cap_high_a: assert property (cap_flip && $past(high_gate_out) |-> low_gate_out && !high_gate_out)
    else $error("high-side flip wrong");
  cap_low_a: assert property (cap_flip && $past(low_gate_out) |-> !low_gate_out)
    else $error("low-side flip wrong");
  olp_stop_a: assert property (bridge_overload && $past(bridge_overload) |->
    !(pfc_gate_out || high_gate_out || low_gate_out)) else $error("gates on in overload");
  olp_bias_a: assert property (bridge_overload && $past(bridge_overload) |-> !bias_assist_en)
    else $error("bias assist on in overload");
  olp_release_a: assert property ($fell(bridge_overload) |-> thermal_shutdown ||
    $past(supply_low_in, 3) || $past(supply_low_in, 4) || $past(supply_low_in, 5) || $past(supply_low_in, 6))
    else $error("overload left without low supply");
  tsd_stop_a: assert property (thermal_shutdown && $past(thermal_shutdown) |->
    !(pfc_gate_out || high_gate_out || low_gate_out)) else $error("gates on in thermal shutdown");
  boot_lock_a: assert property (bootstrap_lockout && $past(bootstrap_lockout) |-> !high_gate_out)
    else $error("high gate on in lockout");
  cover property ($rose(standby));
  cover property ($rose(bridge_overload));
  cover property (cap_flip);
  cover property ($rose(thermal_shutdown));
endmodule

bind lmpf_core lmpf_core_monitor #(.RAMP_STEPS(RAMP_STEPS)) u_mon (.clk(clk), .rst_n(rst_n),
  .fb_above_stby_in(fb_above_stby_in), .supply_low_in(supply_low_in), .pfc_gate_out(pfc_gate_out),
  .high_gate_out(high_gate_out), .low_gate_out(low_gate_out), .bias_assist_en(bias_assist_en),
  .ramp_level(ramp_level), .standby(standby), .bootstrap_lockout(bootstrap_lockout),
  .bridge_overload(bridge_overload), .thermal_shutdown(thermal_shutdown), .cap_flip(cap_flip));

// [bench/lmpf_tank_model.sv]
// Half-bridge and resonant tank: sense comparator levels from the gates
module lmpf_tank_model (
  // Clock and gates
  input wire logic clk,
  input wire logic high_gate_out,
  input wire logic low_gate_out,
  // Operate in the capacitive area
  input wire logic cap_mode,
  // Sense comparators
  output logic rs_above_pos_in,
  output logic rs_below_neg_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int age_h = 0;
  int age_l = 0;
  always @(posedge clk) begin
    age_h <= high_gate_out ? age_h + 1 : 0;
    age_l <= low_gate_out ? age_l + 1 : 0;
  end
  // Capacitive area: current reverses before the side turns off
  assign rs_above_pos_in = high_gate_out && !(cap_mode && age_h > 6);
  assign rs_below_neg_in = low_gate_out && !(cap_mode && age_l > 6);
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the mode and protection sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENT = 64, EXI = 16, SLOW = 200, FAST = 40;
  logic clk = 0, rst_n = 0, cap_mode = 0, high_req = 1, low_req = 0;
  logic fb_above_stby_in = 1, fb_above_off_in = 1, fb_above_on_in = 1, rs_above_ocp_in = 0;
  logic rs_above_fast_in = 0, boot_above_on_in = 1, boot_above_off_in = 1, thermal_hot_in = 0;
  logic supply_low_in = 0, rs_above_pos_in, rs_below_neg_in, pfc_gate_out, high_gate_out, low_gate_out;
  logic bias_assist_en, freq_raise, standby, bootstrap_lockout, bridge_overcurrent, bridge_overload;
  logic thermal_shutdown, cap_flip;
  logic [7:0] ramp_level;
  int miscompares = 0, n_compared = 0, k;
  wire [9:0] st = {bias_assist_en, freq_raise, pfc_gate_out, low_gate_out, high_gate_out,
    cap_flip, bootstrap_lockout, thermal_shutdown, bridge_overload, standby};
  lmpf_core #(.STB_ENTRY_CYC(ENT), .STB_EXIT_CYC(EXI), .OLP_SLOW_CYC(SLOW), .OLP_FAST_CYC(FAST),
    .RAMP_STEPS(8'h08)) u_dut (.clk, .rst_n, .fb_above_stby_in, .fb_above_off_in, .fb_above_on_in,
    .rs_above_pos_in, .rs_below_neg_in, .rs_above_ocp_in, .rs_above_fast_in, .boot_above_on_in,
    .boot_above_off_in, .thermal_hot_in, .supply_low_in, .high_req, .low_req, .pfc_gate_out,
    .high_gate_out, .low_gate_out, .bias_assist_en, .freq_raise, .ramp_level, .standby,
    .bootstrap_lockout, .bridge_overcurrent, .bridge_overload, .thermal_shutdown, .cap_flip);
  lmpf_tank_model u_tank (.clk, .high_gate_out, .low_gate_out, .cap_mode, .rs_above_pos_in,
    .rs_below_neg_in);
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on one status bit, then judge it
  task wt(input string nm, input int i, input logic v, input int n);
    #1;
    k = 0;
    while (st[i] !== v && k < n) begin
      cyc(1);
      k++;
    end
    chk(nm, v, st[i]);
  endtask
  task t_boot;
    @(posedge clk) boot_above_on_in <= 0;
    boot_above_off_in <= 0;
    wt("lockout set", 3, 1, 12);
    cyc(1);
    chk("high gate", 0, high_gate_out);
    @(posedge clk) boot_above_off_in <= 1;
    cyc(10);
    chk("lockout in band", 1, bootstrap_lockout);
    @(posedge clk) boot_above_on_in <= 1;
    wt("lockout clear", 3, 0, 12);
  endtask
  task t_stby;
    @(posedge clk) fb_above_stby_in <= 0;
    cyc(ENT - 24);
    @(posedge clk) fb_above_stby_in <= 1;
    cyc(8);
    @(posedge clk) fb_above_stby_in <= 0;
    cyc(ENT - 4);
    chk("standby early", 0, standby);
    wt("standby", 0, 1, 20);
    cyc(2);
    chk("pfc idle", 0, pfc_gate_out);
    @(posedge clk) fb_above_off_in <= 0;
    fb_above_on_in <= 0;
    for (k = 0; ramp_level !== 8'h08 && k < 30; k++) cyc(1);
    chk("ramp top", 8'h08, ramp_level);
    wt("burst stop", 5, 0, 10);
    @(posedge clk) fb_above_off_in <= 1;
    fb_above_on_in <= 1;
    wt("burst run", 5, 1, 30);
    for (k = 0; ramp_level !== 8'h00 && k < 30; k++) cyc(1);
    chk("ramp bottom", 8'h00, ramp_level);
    @(posedge clk) fb_above_stby_in <= 1;
    cyc(EXI - 6);
    chk("standby held", 1, standby);
    wt("standby exit", 0, 0, 20);
    wt("pfc back", 7, 1, 4);
  endtask
  task t_cap;
    @(posedge clk) cap_mode <= 1;
    wt("flip to low", 4, 1, 20);
    chk("low side", 1, low_gate_out);
    @(posedge clk) high_req <= 0;
    low_req <= 1;
    wt("flip to high", 5, 1, 20);
    wt("cap overload", 1, 1, SLOW + 60);
    cyc(20);
    chk("latched", 1, bridge_overload);
    chk("bias off", 0, bias_assist_en);
    @(posedge clk) cap_mode <= 0;
    // Both requests low is the dead time that ends the capacitive episode
    high_req <= 0;
    low_req <= 0;
    supply_low_in <= 1;
    wt("released", 1, 0, 12);
    @(posedge clk) supply_low_in <= 0;
    high_req <= 1;
    cyc(10);
    chk("stays released", 0, bridge_overload);
  endtask
  task t_ocp;
    @(posedge clk) rs_above_ocp_in <= 1;
    rs_above_fast_in <= 1;
    wt("freq raise", 8, 1, 10);
    chk("overcurrent flag", 1, bridge_overcurrent);
    cyc(FAST / 2);
    @(posedge clk) rs_above_ocp_in <= 0;
    rs_above_fast_in <= 0;
    cyc(10);
    @(posedge clk) rs_above_ocp_in <= 1;
    rs_above_fast_in <= 1;
    cyc(FAST - 2);
    chk("fast early", 0, bridge_overload);
    wt("fast overload", 1, 1, 15);
    cyc(2);
    chk("gates stopped", 0, {pfc_gate_out, high_gate_out, low_gate_out});
    // Stopped bridge carries no current, so the sense pins go quiet
    @(posedge clk) rs_above_fast_in <= 0;
    rs_above_ocp_in <= 0;
    supply_low_in <= 1;
    wt("released", 1, 0, 12);
    @(posedge clk) supply_low_in <= 0;
    rs_above_ocp_in <= 1;
    cyc(SLOW - 10);
    chk("slow early", 0, bridge_overload);
    wt("slow overload", 1, 1, 30);
    @(posedge clk) rs_above_ocp_in <= 0;
    supply_low_in <= 1;
    wt("released", 1, 0, 12);
    @(posedge clk) supply_low_in <= 0;
  endtask
  task t_tsd;
    @(posedge clk) thermal_hot_in <= 1;
    wt("thermal", 2, 1, 8);
    cyc(1);
    chk("gates stopped", 0, {pfc_gate_out, high_gate_out, low_gate_out});
    @(posedge clk) thermal_hot_in <= 0;
    cyc(10);
    chk("thermal held", 1, thermal_shutdown);
    @(posedge clk) supply_low_in <= 1;
    wt("thermal left", 2, 0, 10);
  endtask
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Whole sequence is about 800 cycles; a generous limit
  initial begin
    #40000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    cyc(4);
    chk("reset levels", 8'h18, {bias_assist_en, bootstrap_lockout, pfc_gate_out, standby, bridge_overload});
    @(posedge clk) rst_n <= 1;
    cyc(8);
    t_boot;
    t_stby;
    t_cap;
    t_ocp;
    t_tsd;
    report_and_stop;
  end
endmodule

// [hdl/lmpf_core.v]
// Standby, burst, capacitive-mode and protection sequencer for the resonant half-bridge
// Overview of operation
// R1: Standby entered after feedback low 512 ms
// R2: Standby idles PFC gate, bursts bridge gates
// R3: Standby exits after feedback high 3 ms
// R4: Burst: feedback low ramps frequency up, stops
// R5: Burst: feedback high restarts, ramps frequency down
// R6: High side on, positive crossing flips sides
// R7: Low side on, negative crossing flips sides
// R8: Persistent capacitive mode triggers overload shutdown
// R9: Sense at overcurrent level raises frequency
// R10: Persistent overcurrent triggers overload shutdown
// R11: Overload delay 153.9 ms slow, 1.99 ms fast
// R12: Overload latches off, releases at low supply
// R13: High driver enabled at bootstrap 6.8 V
// R14: High driver disabled at bootstrap 6.4 V
// R15: Overtemperature stops all switching
// R16: Thermal release needs low supply, cool die
// R17: Standby filter timers restart when condition lapses
// R18: Overload timer runs only during fault condition
`include "lmpf_map.vh"
module lmpf_core #(
  parameter [31:0] STB_ENTRY_CYC = `LMPF_STB_ENTRY_CYC,
  parameter [31:0] STB_EXIT_CYC = `LMPF_STB_EXIT_CYC,
  parameter [31:0] OLP_SLOW_CYC = `LMPF_OLP_SLOW_CYC,
  parameter [31:0] OLP_FAST_CYC = `LMPF_OLP_FAST_CYC,
  parameter [7:0] RAMP_STEPS = `LMPF_RAMP_STEPS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Comparator pins
  input wire fb_above_stby_in,
  input wire fb_above_off_in,
  input wire fb_above_on_in,
  input wire rs_above_pos_in,
  input wire rs_below_neg_in,
  input wire rs_above_ocp_in,
  input wire rs_above_fast_in,
  input wire boot_above_on_in,
  input wire boot_above_off_in,
  input wire thermal_hot_in,
  input wire supply_low_in,
  // Gate requests from the oscillator
  input wire high_req,
  input wire low_req,
  // Gate and status outputs
  output reg pfc_gate_out,
  output reg high_gate_out,
  output reg low_gate_out,
  output reg bias_assist_en,
  output reg freq_raise,
  output reg [7:0] ramp_level,
  output reg standby,
  output reg bootstrap_lockout,
  output reg bridge_overcurrent,
  output reg bridge_overload,
  output reg thermal_shutdown,
  output reg cap_flip
);
  wire fb_stby;
  wire fb_off;
  wire fb_on;
  wire rs_pos;
  wire rs_neg;
  wire rs_ocp;
  wire rs_fast;
  wire boot_on;
  wire boot_off;
  wire hot;
  wire supply_lockout;
  // Comparator pins are asynchronous; each filter costs four cycles of latency
  lmpf_sync u_s0 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(fb_above_stby_in),
    .level(fb_stby));
  lmpf_sync u_s1 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(fb_above_off_in),
    .level(fb_off));
  lmpf_sync u_s2 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(fb_above_on_in),
    .level(fb_on));
  lmpf_sync u_s3 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(rs_above_pos_in),
    .level(rs_pos));
  lmpf_sync u_s4 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(rs_below_neg_in),
    .level(rs_neg));
  lmpf_sync u_s5 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(rs_above_ocp_in),
    .level(rs_ocp));
  lmpf_sync u_s6 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(rs_above_fast_in),
    .level(rs_fast));
  lmpf_sync u_s7 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(boot_above_on_in),
    .level(boot_on));
  lmpf_sync u_s8 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(boot_above_off_in),
    .level(boot_off));
  lmpf_sync u_s9 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(thermal_hot_in),
    .level(hot));
  lmpf_sync u_s10 (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(supply_low_in),
    .level(supply_lockout));

  // Filter timers
  wire stb_entry_done;
  wire stb_exit_done;
  wire olp_slow_done;
  wire olp_fast_done;
  reg cap_seen;
  wire fault_run;
  assign fault_run = rs_ocp || cap_seen;
  lmpf_timer #(.LIMIT(STB_ENTRY_CYC)) u_t_entry (
    .clk(clk),
    .rst_n(rst_n),
    .run(!fb_stby && !standby),
    .done(stb_entry_done)); // R1 R17
  lmpf_timer #(.LIMIT(STB_EXIT_CYC)) u_t_exit (
    .clk(clk),
    .rst_n(rst_n),
    .run(fb_stby && standby),
    .done(stb_exit_done)); // R3 R17
  // Slow timer sees overcurrent and capacitive mode; the fast one only the high sense level
  lmpf_timer #(.LIMIT(OLP_SLOW_CYC)) u_t_slow (
    .clk(clk),
    .rst_n(rst_n),
    .run(fault_run),
    .done(olp_slow_done)); // R8 R10 R11 R18
  lmpf_timer #(.LIMIT(OLP_FAST_CYC)) u_t_fast (
    .clk(clk),
    .rst_n(rst_n),
    .run(rs_fast),
    .done(olp_fast_done)); // R11 R18

  // Burst and protection state
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] next_ramp;
  wire olp_trip;
  assign olp_trip = olp_slow_done || olp_fast_done; // R8 R10 R11
  always @* begin
    next_state = state;
    next_ramp = ramp_level;
    case (state)
      `LMPF_ST_RUN: begin
        next_ramp = 8'h00;
        if (standby && !fb_off)
          next_state = `LMPF_ST_RAMP_UP; // R4
      end
      `LMPF_ST_RAMP_UP: begin
        if (fb_on)
          next_state = `LMPF_ST_RAMP_DN; // R5
        else if (ramp_level == RAMP_STEPS)
          next_state = `LMPF_ST_IDLE; // R4
        else
          next_ramp = ramp_level + 8'h01; // R4
      end
      `LMPF_ST_IDLE: begin
        if (fb_on)
          next_state = `LMPF_ST_RAMP_DN; // R5
        else if (!standby)
          next_state = `LMPF_ST_RAMP_DN;
      end
      `LMPF_ST_RAMP_DN: begin
        if (ramp_level == 8'h00)
          next_state = `LMPF_ST_RUN; // R5
        else if (standby && !fb_off)
          next_state = `LMPF_ST_RAMP_UP;
        else
          next_ramp = ramp_level - 8'h01; // R5
      end
      `LMPF_ST_OLP: begin
        next_ramp = 8'h00;
        if (supply_lockout)
          next_state = `LMPF_ST_RUN; // R12
      end
      `LMPF_ST_TSD: begin
        next_ramp = 8'h00;
        if (supply_lockout && !hot)
          next_state = `LMPF_ST_RUN; // R16
      end
      default: begin
        next_state = `LMPF_ST_RUN;
        next_ramp = 8'h00;
      end
    endcase
    // Thermal outranks overload; both override burst handling
    if (hot && state != `LMPF_ST_TSD)
      next_state = `LMPF_ST_TSD; // R15
    else if (olp_trip && state != `LMPF_ST_OLP && state != `LMPF_ST_TSD)
      next_state = `LMPF_ST_OLP; // R8 R10
  end

  wire stopped;
  assign stopped = (state == `LMPF_ST_OLP) || (state == `LMPF_ST_TSD);
  wire bridge_idle;
  assign bridge_idle = stopped || (state == `LMPF_ST_IDLE);
  // Gates drop on the very edge that enters a stop, not one cycle later
  wire gates_off;
  assign gates_off = bridge_idle || (next_state == `LMPF_ST_OLP) || (next_state == `LMPF_ST_TSD);

  // Side flip on capacitive detection is held until the oscillator moves on
  reg rs_pos_d;
  reg rs_neg_d;
  reg force_low;
  reg force_high;
  wire cap_hi;
  wire cap_lo;
  assign cap_hi = high_gate_out && rs_pos_d && !rs_pos; // R6
  assign cap_lo = low_gate_out && rs_neg_d && !rs_neg; // R7

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= `LMPF_ST_RUN;
      ramp_level <= 8'h00;
      standby <= 1'b0;
      pfc_gate_out <= 1'b0;
      high_gate_out <= 1'b0;
      low_gate_out <= 1'b0;
      bias_assist_en <= 1'b1;
      freq_raise <= 1'b0;
      bootstrap_lockout <= 1'b1;
      bridge_overcurrent <= 1'b0;
      bridge_overload <= 1'b0;
      thermal_shutdown <= 1'b0;
      cap_flip <= 1'b0;
      cap_seen <= 1'b0;
      rs_pos_d <= 1'b0;
      rs_neg_d <= 1'b0;
      force_low <= 1'b0;
      force_high <= 1'b0;
    end else begin
      state <= next_state;
      ramp_level <= next_ramp;
      rs_pos_d <= rs_pos;
      rs_neg_d <= rs_neg;
      if (stopped)
        standby <= 1'b0;
      else if (stb_entry_done)
        standby <= 1'b1; // R1
      else if (stb_exit_done)
        standby <= 1'b0; // R3
      if (boot_on)
        bootstrap_lockout <= 1'b0; // R13
      else if (!boot_off)
        bootstrap_lockout <= 1'b1; // R14
      bridge_overcurrent <= rs_ocp;
      freq_raise <= rs_ocp && !stopped; // R9
      bridge_overload <= (next_state == `LMPF_ST_OLP);
      thermal_shutdown <= (next_state == `LMPF_ST_TSD);
      bias_assist_en <= (next_state != `LMPF_ST_OLP); // R12
      // Flag only a flip that reaches the gates, never one swallowed by a stop
      cap_flip <= (cap_hi || cap_lo) && !gates_off; // R6 R7
      // Stays set until a dead time with both requests low and neither side forced
      if (cap_hi || cap_lo)
        cap_seen <= 1'b1; // R8
      else if (!high_req && !low_req && !force_low && !force_high)
        cap_seen <= 1'b0; // R18
      if (cap_hi)
        force_low <= 1'b1; // R6
      else if (!high_req)
        force_low <= 1'b0;
      if (cap_lo)
        force_high <= 1'b1; // R7
      else if (!low_req)
        force_high <= 1'b0;
      pfc_gate_out <= !stopped && !standby && next_state != `LMPF_ST_OLP && next_state != `LMPF_ST_TSD; // R2
      if (gates_off) begin
        high_gate_out <= 1'b0; // R2 R4 R15
        low_gate_out <= 1'b0;
      end else if (cap_hi) begin
        high_gate_out <= 1'b0; // R6
        low_gate_out <= 1'b1;
      end else if (cap_lo) begin
        low_gate_out <= 1'b0; // R7
        high_gate_out <= !bootstrap_lockout;
      end else begin
        high_gate_out <= !bootstrap_lockout && !force_low && (high_req || force_high) && !low_gate_out; // R13 R14
        low_gate_out <= !force_high && (low_req || force_low) && !high_gate_out;
      end
    end
  end
endmodule

// [hdl/lmpf_map.vh]
// Timing counts and field codes for the resonant mode and protection sequencer
`ifndef LMPF_MAP_VH
`define LMPF_MAP_VH
`define LMPF_CLK_MHZ 250
`define LMPF_STB_ENTRY_MS 512
`define LMPF_STB_EXIT_MS 3
`define LMPF_OLP_SLOW_US 153900
`define LMPF_OLP_FAST_US 1990
`define LMPF_STB_ENTRY_CYC (`LMPF_STB_ENTRY_MS * 1000 * `LMPF_CLK_MHZ)
`define LMPF_STB_EXIT_CYC (`LMPF_STB_EXIT_MS * 1000 * `LMPF_CLK_MHZ)
`define LMPF_OLP_SLOW_CYC (`LMPF_OLP_SLOW_US * `LMPF_CLK_MHZ)
`define LMPF_OLP_FAST_CYC (`LMPF_OLP_FAST_US * `LMPF_CLK_MHZ)
`define LMPF_CNT_W 32
`define LMPF_RAMP_STEPS 8'h40
`define LMPF_ST_RUN 3'h0
`define LMPF_ST_RAMP_UP 3'h1
`define LMPF_ST_IDLE 3'h2
`define LMPF_ST_RAMP_DN 3'h3
`define LMPF_ST_OLP 3'h4
`define LMPF_ST_TSD 3'h5
`endif

// [hdl/lmpf_sync.v]
// Three-stage pin synchroniser with agreement filter
module lmpf_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Pin and filtered level
  input wire pin_in,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      // Change only when the two settled stages agree
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule

// [hdl/lmpf_timer.v]
// Persistence timer: counts while a condition holds, clears when it lapses
module lmpf_timer #(
  parameter [31:0] LIMIT = 32'h0000_0010
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Condition and result
  input wire run,
  output wire done
);
  reg [31:0] count;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      count <= 32'h0;
    else if (!run)
      count <= 32'h0;
    else if (count < LIMIT)
      count <= count + 32'h1;
  end
  assign done = run && (count >= LIMIT);
endmodule
